/* File: bsa_cfg.svh */
// Chain positions, cell defaults and timing figures of the scan segment
`ifndef BSA_CFG_SVH
`define BSA_CFG_SVH
`define BSA_LEN 141
`define BSA_TOP 140
`define BSA_SEG_LO 76
`define BSA_CMP_IDLE 140
`define BSA_CMP_OUT 139
`define BSA_CMP_CHANNEL_MUX_SELECT 138
`define BSA_CMP_BG 137
`define BSA_COMP 136
`define BSA_RSVD_A 135
`define BSA_ACLK 134
`define BSA_TEST_EN 133
`define BSA_RSVD_B 132
`define BSA_BG_EN 131
`define BSA_CONV_EN 130
`define BSA_AMP_EN 129
`define BSA_DAC_HI 128
`define BSA_DAC_LO 119
`define BSA_BYPASS 118
`define BSA_G10 117
`define BSA_G20 116
`define BSA_GND_EN 115
`define BSA_HOLD 114
`define BSA_IREF 113
`define BSA_MUX_HI 112
`define BSA_MUX_LO 105
`define BSA_NEG_HI 104
`define BSA_NEG_LO 102
`define BSA_PASS 101
`define BSA_PRECHARGE_N_CELL 100
`define BSA_SWITCHCAP_TEST_ENABLE 99
`define BSA_SETTLE 98
`define BSA_VCCREF 97
`define BSA_PIN_HI 96
`define BSA_PIN_CELLS 3
`define BSA_PB_PINS 7
`define BSA_DAC_MID 10'h200
`define BSA_MUX_TEST 8'h08
`define BSA_DUMMY_CMPS 10
`define BSA_STEPS 11
`define BSA_HALF_STEPS 5
`define BSA_LOW_CHECK 6
`define BSA_SETTLE_NS 200
`define BSA_CLK_NS 100
`define BSA_HOLD_MAX_NS 1000000
`endif

/* File: bsa_pkg.sv */
// Types used by the scan test controller and the bench; the device segment uses none of them
package bsa_pkg;
	typedef enum logic [5:0] {
		BSA_IDLE = 6'h01,
		BSA_CAPT = 6'h02,
		BSA_SHIFT = 6'h04,
		BSA_UPD = 6'h08,
		BSA_WAIT = 6'h10,
		BSA_DONE = 6'h20
	} bsa_host_state_type;
	typedef logic [9:0] bsa_code_type;
	typedef logic [7:0] bsa_mux_type;
endpackage

/* File: bsa_link_if.sv */
// Scan link between the test controller and the device segment
`timescale 1ns/1ps
interface bsa_link_if;
	logic tck;
	logic tdi;
	logic tdo;
	logic capture;
	logic shift;
	logic update;
	logic extest;
	modport dev (
		input tck,
		input tdi,
		input capture,
		input shift,
		input update,
		input extest,
		output tdo
	);
	modport host (
		output tck,
		output tdi,
		output capture,
		output shift,
		output update,
		output extest,
		input tdo
	);
endinterface

/* File: bsa_device.sv */
// Boundary-scan segment for comparator, converter cells and port B pins
`timescale 1ns/1ps
`include "bsa_cfg.svh"
module bsa_device #(
	parameter int PB_PINS = `BSA_PB_PINS
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	bsa_link_if.dev link,
	input wire logic comp_result,
	input wire logic comparator_out,
	input wire logic [PB_PINS-1:0] pin_in,
	input wire logic [`BSA_TOP:`BSA_VCCREF] func_analog,
	input wire logic [PB_PINS-1:0] func_pin_data,
	input wire logic [PB_PINS-1:0] func_pin_dir,
	input wire logic [PB_PINS-1:0] func_pin_pullup,
	output logic [`BSA_TOP:`BSA_VCCREF] analog_ctrl_q,
	output logic [PB_PINS-1:0] pin_out_q,
	output logic [PB_PINS-1:0] pin_oe_n_q,
	output logic [PB_PINS-1:0] pin_pullup_q,
	output logic dummy_busy_q,
	output logic extest_active_q
);
	import bsa_pkg::*;

	localparam int CNT_W = $clog2(`BSA_DUMMY_CMPS + 1);
	localparam logic [CNT_W-1:0] DUMMY_N = CNT_W'(`BSA_DUMMY_CMPS);

	generate
		if (PB_PINS < 1 || PB_PINS > `BSA_PB_PINS) begin : g_bad_pins
			$error("bsa_device: PB_PINS out of range");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Link clock domain

	logic [1:0] rst_sync_q;
	logic tck_rst;
	logic [PB_PINS+1:0] obs_meta_q;
	logic [PB_PINS+1:0] obs_q;
	logic [`BSA_TOP:0] chain_q;
	logic [`BSA_TOP:0] cap_vec;
	logic [`BSA_TOP:`BSA_SEG_LO] upd_q;
	logic upd_flag_q;
	logic ext_tck_q;

	// Reset crosses into the link domain before use
	always_ff @(posedge link.tck) begin
		rst_sync_q <= {rst_sync_q[0], sys_rst};
	end
	assign tck_rst = rst_sync_q[1];

	// Analog results and pin levels are asynchronous to the link clock
	always_ff @(posedge link.tck) begin
		obs_meta_q <= {comp_result, comparator_out, pin_in};
		obs_q <= obs_meta_q;
	end

	// Control cells capture what they apply; observe cells capture inputs
	always_comb begin
		cap_vec = chain_q;
		cap_vec[`BSA_TOP:`BSA_SEG_LO] = upd_q;
		cap_vec[`BSA_COMP] = obs_q[PB_PINS+1];
		cap_vec[`BSA_CMP_OUT] = obs_q[PB_PINS];
		for (int i = 0; i < PB_PINS; i++) begin
			cap_vec[`BSA_PIN_HI - `BSA_PIN_CELLS*i] = obs_q[i];
		end
	end

	// Cells below the segment hold pass-through positions only, which
	// keeps the chain length and the port A / port C layout intact
	always_ff @(posedge link.tck) begin
		if (tck_rst) begin
			chain_q <= '0;
		end else if (link.capture) begin
			chain_q <= cap_vec;
		end else if (link.shift) begin
			chain_q <= {link.tdi, chain_q[`BSA_TOP:1]};
		end
	end

	assign link.tdo = chain_q[0];

	// Level flag, not a toggle: the link clock may stand still in reset,
	// and a toggle that never saw reset would stay unknown for good
	always_ff @(posedge link.tck) begin
		if (tck_rst) begin
			upd_q <= '0;
			upd_flag_q <= 1'h0;
		end else begin
			upd_flag_q <= link.update;
			if (link.update) begin
				upd_q <= chain_q[`BSA_TOP:`BSA_SEG_LO];
			end
		end
	end

	always_ff @(posedge link.tck) begin
		if (tck_rst) begin
			ext_tck_q <= 1'h0;
		end else begin
			ext_tck_q <= link.extest;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core clock domain

	logic ext_meta_q;
	logic ext_q;
	logic flg_meta_q;
	logic flg_sync_q;
	logic flg_prev_q;
	logic [`BSA_TOP:`BSA_SEG_LO] app_q;
	logic [`BSA_TOP:`BSA_VCCREF] ana_d;
	logic conv_prev_q;
	logic [CNT_W-1:0] dummy_cnt_q;
	logic [CNT_W-1:0] dummy_cnt_d;

	always_ff @(posedge core_clk) begin
		ext_meta_q <= ext_tck_q;
		ext_q <= ext_meta_q;
		flg_meta_q <= upd_flag_q;
		flg_sync_q <= flg_meta_q;
	end

	// Pulse handshake: the update word stands for many link clocks after
	// the flag rises; the flag lasts one link period, so the link clock
	// must be slower than two core clocks
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			flg_prev_q <= 1'h0;
			app_q <= '0;
		end else begin
			flg_prev_q <= flg_sync_q;
			if (flg_sync_q && !flg_prev_q) begin
				app_q <= upd_q;
			end
		end
	end

	// Observe-only positions drive nothing into the analog block
	always_comb begin
		ana_d = ext_q ? app_q[`BSA_TOP:`BSA_VCCREF] : func_analog;
		ana_d[`BSA_CMP_OUT] = 1'h0;
		ana_d[`BSA_COMP] = 1'h0;
	end

	// Hold low samples and precharge low clears the latch in the analog
	// block; both cells pass straight through to it
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			analog_ctrl_q <= '0;
			extest_active_q <= 1'h0;
		end else begin
			analog_ctrl_q <= ana_d;
			extest_active_q <= ext_q;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < PB_PINS; gi++) begin : g_pin
			localparam int DATA_POS = `BSA_PIN_HI - `BSA_PIN_CELLS*gi;
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					pin_out_q[gi] <= 1'h0;
					pin_oe_n_q[gi] <= 1'h1;
					pin_pullup_q[gi] <= 1'h0;
				end else if (ext_q) begin
					pin_out_q[gi] <= app_q[DATA_POS];
					pin_oe_n_q[gi] <= ~app_q[DATA_POS-1];
					pin_pullup_q[gi] <= app_q[DATA_POS-2];
				end else begin
					pin_out_q[gi] <= func_pin_data[gi];
					pin_oe_n_q[gi] <= ~func_pin_dir[gi];
					pin_pullup_q[gi] <= func_pin_pullup[gi];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Dummy conversion in normal mode, one comparison per core clock

	always_comb begin
		dummy_cnt_d = dummy_cnt_q;
		if (ext_q) begin
			dummy_cnt_d = '0;
		end else if (func_analog[`BSA_CONV_EN] && !conv_prev_q) begin
			dummy_cnt_d = DUMMY_N;
		end else if (dummy_cnt_q != '0) begin
			dummy_cnt_d = dummy_cnt_q - CNT_W'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			conv_prev_q <= 1'h0;
			dummy_cnt_q <= '0;
			dummy_busy_q <= 1'h0;
		end else begin
			conv_prev_q <= func_analog[`BSA_CONV_EN];
			dummy_cnt_q <= dummy_cnt_d;
			dummy_busy_q <= (dummy_cnt_d != '0);
		end
	end
endmodule

/* File: bsa_host.sv */
// Scan test controller running the converter limit check over the link
`timescale 1ns/1ps
`include "bsa_cfg.svh"
module bsa_host #(
	parameter int TCK_DIV = 4,
	parameter int HOLD_MAX_NS = `BSA_HOLD_MAX_NS
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	bsa_link_if.host link,
	input wire logic start,
	input wire bsa_pkg::bsa_code_type lower_limit,
	input wire bsa_pkg::bsa_code_type upper_limit,
	input wire bsa_pkg::bsa_mux_type channel_mux_select,
	output logic busy_q,
	output logic done_q,
	output logic low_ok_q,
	output logic high_ok_q,
	output logic pass_q
);
	import bsa_pkg::*;

	localparam int TCK_NS = 2 * TCK_DIV * `BSA_CLK_NS;
	localparam int SETTLE_RAW = (`BSA_SETTLE_NS + TCK_NS - 1) / TCK_NS;
	localparam int SETTLE_TCK = SETTLE_RAW < 1 ? 1 : SETTLE_RAW;

	// tdo passes two flops; a sample half a link period late needs 3
	generate
		if (TCK_DIV < 3 || TCK_DIV > 255) begin : g_bad_div
			$error("bsa_host: TCK_DIV out of range");
		end
		if (5 * `BSA_LEN * TCK_NS > HOLD_MAX_NS) begin : g_slow_tck
			$error("bsa_host: link clock too slow for hold time");
		end
	endgenerate

	// One step of the limit check; cells not named keep idle values
	function automatic logic [`BSA_TOP:0] step_vec(
		input logic [3:0] step,
		input bsa_code_type lo,
		input bsa_code_type hi,
		input bsa_mux_type mux
	);
		logic [`BSA_TOP:0] v;
		logic [3:0] p;
		v = '0;
		v[`BSA_BYPASS] = 1'h1;
		v[`BSA_PASS] = 1'h1;
		v[`BSA_PRECHARGE_N_CELL] = 1'h1;
		v[`BSA_HOLD] = 1'h1;
		v[`BSA_CONV_EN] = 1'h1;
		v[`BSA_MUX_HI:`BSA_MUX_LO] = mux;
		v[`BSA_DAC_HI:`BSA_DAC_LO] = `BSA_DAC_MID;
		p = (step <= 4'(`BSA_LOW_CHECK)) ? step - 4'h1
			: step - 4'(`BSA_LOW_CHECK);
		if (p == 4'h1) begin
			v[`BSA_HOLD] = 1'h0;
		end
		if (p == 4'h3 || p == 4'h4) begin
			v[`BSA_DAC_HI:`BSA_DAC_LO] =
				(step <= 4'(`BSA_LOW_CHECK)) ? lo : hi;
		end
		if (p == 4'h4) begin
			v[`BSA_PRECHARGE_N_CELL] = 1'h0;
		end
		return v; // all pin cells stay zero
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Link clock divider; link signals change only as the clock falls

	logic [7:0] div_q;
	logic tck_q;
	logic tick;
	logic fall_tick;

	assign tick = (div_q == 8'(TCK_DIV - 1));
	assign fall_tick = tick & tck_q;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			div_q <= '0;
			tck_q <= 1'h0;
		end else if (tick) begin
			div_q <= '0;
			tck_q <= ~tck_q;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	logic tdo_meta_q;
	logic tdo_sync_q;

	always_ff @(posedge core_clk) begin
		tdo_meta_q <= link.tdo;
		tdo_sync_q <= tdo_meta_q;
	end

	////////////////////////////////////////////////////////////////////////
	// Step sequencer

	bsa_host_state_type state_q;
	logic go_q;
	logic [3:0] step_q;
	logic [7:0] bit_q;
	logic [7:0] wait_q;
	logic [`BSA_TOP:0] vec_q;
	logic tdi_q;
	logic cap_q;
	logic shift_q;
	logic upd_q;
	logic ext_q;

	assign link.tck = tck_q;
	assign link.tdi = tdi_q;
	assign link.capture = cap_q;
	assign link.shift = shift_q;
	assign link.update = upd_q;
	assign link.extest = ext_q;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q <= BSA_IDLE;
			go_q <= 1'h0;
			step_q <= 4'h0;
			bit_q <= 8'h00;
			wait_q <= 8'h00;
			vec_q <= '0;
			tdi_q <= 1'h0;
			cap_q <= 1'h0;
			shift_q <= 1'h0;
			upd_q <= 1'h0;
			ext_q <= 1'h0;
		end else begin
			if (start && state_q == BSA_IDLE) begin
				go_q <= 1'h1;
			end
			if (fall_tick) begin
				unique case (state_q)
				BSA_IDLE: begin
					if (go_q) begin
						go_q <= 1'h0;
						step_q <= 4'h1;
						vec_q <= step_vec(4'h1, lower_limit, upper_limit,
							channel_mux_select);
						ext_q <= 1'h0;
						cap_q <= 1'h1;
						state_q <= BSA_CAPT;
					end
				end
				BSA_CAPT: begin
					cap_q <= 1'h0;
					shift_q <= 1'h1;
					bit_q <= 8'h00;
					tdi_q <= vec_q[0];
					state_q <= BSA_SHIFT;
				end
				BSA_SHIFT: begin
					if (bit_q == 8'(`BSA_TOP)) begin
						shift_q <= 1'h0;
						upd_q <= 1'h1;
						state_q <= BSA_UPD;
					end else begin
						bit_q <= bit_q + 8'h01;
						tdi_q <= vec_q[bit_q + 8'h01];
					end
				end
				BSA_UPD: begin
					upd_q <= 1'h0;
					wait_q <= 8'(SETTLE_TCK);
					state_q <= BSA_WAIT;
				end
				BSA_WAIT: begin
					if (wait_q > 8'h01) begin
						wait_q <= wait_q - 8'h01;
					end else if (step_q == 4'(`BSA_STEPS)) begin
						state_q <= BSA_DONE;
					end else begin
						step_q <= step_q + 4'h1;
						vec_q <= step_vec(step_q + 4'h1, lower_limit,
							upper_limit, channel_mux_select);
						ext_q <= 1'h1;
						cap_q <= 1'h1;
						state_q <= BSA_CAPT;
					end
				end
				BSA_DONE: begin
					state_q <= BSA_IDLE;
				end
				endcase
			end
		end
	end

	// The comparator bit is judged from the scan that loads this step
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			low_ok_q <= 1'h0;
			high_ok_q <= 1'h0;
		end else if (go_q && state_q == BSA_IDLE) begin
			low_ok_q <= 1'h0;
			high_ok_q <= 1'h0;
		end else if (fall_tick && state_q == BSA_SHIFT
			&& bit_q == 8'(`BSA_COMP - 1)) begin
			if (step_q == 4'(`BSA_LOW_CHECK)) begin
				low_ok_q <= ~tdo_sync_q;
			end
			if (step_q == 4'(`BSA_STEPS)) begin
				high_ok_q <= tdo_sync_q;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			busy_q <= 1'h0;
			done_q <= 1'h0;
			pass_q <= 1'h0;
		end else begin
			busy_q <= (state_q != BSA_IDLE) || go_q;
			if (go_q) begin
				done_q <= 1'h0;
				pass_q <= 1'h0;
			end else if (state_q == BSA_DONE) begin
				done_q <= 1'h1;
				pass_q <= low_ok_q & high_ok_q;
			end
		end
	end
endmodule

/* File: bsa_link_monitor.sv */
// Protocol checks on the scan link between host and device
`timescale 1ns/1ps
module bsa_link_monitor (
	input wire logic tck,
	input wire logic sys_rst,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic capture,
	input wire logic shift,
	input wire logic update,
	input wire logic extest
);
	logic [7:0] shift_cnt_q;
	logic [3:0] step_cnt_q;
	logic [140:0] word_q;
	default clocking dc @(posedge tck); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////////
	// Tck stands still in reset, so the counters clear without it
	always_ff @(posedge tck or posedge sys_rst) begin
		if (sys_rst) begin
			shift_cnt_q <= 8'h00;
		end else if (capture) begin
			shift_cnt_q <= 8'h00;
		end else if (shift) begin
			shift_cnt_q <= shift_cnt_q + 8'h01;
		end
	end
	always_ff @(posedge tck or posedge sys_rst) begin
		if (sys_rst) begin
			step_cnt_q <= 4'h0;
		end else if (capture) begin
			step_cnt_q <= (step_cnt_q == 4'hA) ? 4'h0 : step_cnt_q + 4'h1;
		end
	end
	always_ff @(posedge tck) begin
		if (shift && shift_cnt_q <= 8'h8C) begin
			word_q[shift_cnt_q] <= tdi;
		end
	end
	////////////////////////////////////////////////////////////////////
	sequence s_shift_run;
		shift ##140 shift;
	endsequence
	sequence s_update_end;
		update && !shift && !capture;
	endsequence
	property p_step;
		capture |=> s_shift_run ##1 s_update_end;
	endproperty
	a_scan_step_shape: assert property (p_step)
		else $error("scan step shape wrong");
	a_shift_bit_count: assert property (shift ##1 !shift |-> shift_cnt_q == 8'h8D)
		else $error("shift count not chain length");
	a_capture_one_tck: assert property (capture |=> !capture && shift)
		else $error("capture not single");
	a_update_then_idle: assert property (update |=> !update && !capture)
		else $error("no idle after update");
	a_extest_steady: assert property (shift |-> $stable(extest))
		else $error("instruction changed in shift");
	a_preload_first: assert property (capture && step_cnt_q == 4'h0 |-> !extest)
		else $error("first step not preload");
	a_extest_later: assert property (capture && step_cnt_q != 4'h0 |-> extest)
		else $error("later step not extest");
	a_reserved_zero: assert property (shift && (shift_cnt_q == 8'h87 ||
		shift_cnt_q == 8'h84) |-> !tdi)
		else $error("reserved cell not zero");
	a_mid_in_sample: assert property (update && !word_q[114] |->
		word_q[128:119] == 10'h200)
		else $error("code not midpoint while sampling");
	a_one_source: assert property (update |->
		$onehot({word_q[112:105], word_q[115]}) && !word_q[137])
		else $error("negative input sources wrong");
	a_gain_off: assert property (update |-> !word_q[117] && !word_q[116])
		else $error("gain stage enabled");
	a_pin_input: assert property (update |-> word_q[96:76] == 21'h0)
		else $error("pin cells not input without pull-up");
	a_limit_hold: assert property (update && !word_q[100] |->
		word_q[114] && word_q[128:119] != 10'h200)
		else $error("precharge without held limit");
endmodule

/* File: boundary_scan_adc_chain_tb_top.sv */
// Bench joining host and device and running limit checks
`timescale 1ns/1ps
`include "bsa_cfg.svh"
module boundary_scan_adc_chain_tb_top;
	import bsa_pkg::*;
	logic core_clk;
	logic sys_rst;
	logic start;
	bsa_code_type lower_limit;
	bsa_code_type upper_limit;
	bsa_mux_type mux_sel;
	bsa_code_type vin;
	logic comp_result;
	logic comparator_out;
	logic [6:0] pin_in;
	logic [140:97] func_analog;
	logic [6:0] func_pin_data;
	logic [6:0] func_pin_dir;
	logic [6:0] func_pin_pullup;
	logic [140:97] analog_ctrl_q;
	logic [6:0] pin_out_q;
	logic [6:0] pin_oe_n_q;
	logic [6:0] pin_pullup_q;
	logic dummy_busy_q;
	logic extest_active_q;
	logic busy_q;
	logic done_q;
	logic low_ok_q;
	logic high_ok_q;
	logic pass_q;
	int fails;
	int comparisons;
	bsa_link_if i_bsa_link_if ();
	bsa_host i_bsa_host (.core_clk(core_clk), .sys_rst(sys_rst),
		.link(i_bsa_link_if), .start(start), .lower_limit(lower_limit),
		.upper_limit(upper_limit), .channel_mux_select(mux_sel),
		.busy_q(busy_q), .done_q(done_q), .low_ok_q(low_ok_q),
		.high_ok_q(high_ok_q), .pass_q(pass_q));
	bsa_device i_bsa_device (.core_clk(core_clk), .sys_rst(sys_rst),
		.link(i_bsa_link_if), .comp_result(comp_result),
		.comparator_out(comparator_out), .pin_in(pin_in),
		.func_analog(func_analog), .func_pin_data(func_pin_data),
		.func_pin_dir(func_pin_dir), .func_pin_pullup(func_pin_pullup),
		.analog_ctrl_q(analog_ctrl_q), .pin_out_q(pin_out_q),
		.pin_oe_n_q(pin_oe_n_q), .pin_pullup_q(pin_pullup_q),
		.dummy_busy_q(dummy_busy_q), .extest_active_q(extest_active_q));
	bsa_link_monitor i_bsa_link_monitor (.tck(i_bsa_link_if.tck),
		.sys_rst(sys_rst), .tdi(i_bsa_link_if.tdi), .tdo(i_bsa_link_if.tdo),
		.capture(i_bsa_link_if.capture), .shift(i_bsa_link_if.shift),
		.update(i_bsa_link_if.update), .extest(i_bsa_link_if.extest));
	// Ideal comparator; hold and precharge are not modelled
	assign comp_result = analog_ctrl_q[128:119] > vin;
	////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic t_normal();
		logic [140:97] exp;
		int n;
		exp = 44'h0F0F0F0F0F0;
		func_analog <= exp;
		func_pin_data <= 7'h55;
		func_pin_dir <= 7'h33;
		func_pin_pullup <= 7'h0F;
		exp[139] = 1'b0;
		exp[136] = 1'b0;
		repeat (8) @(posedge core_clk);
		#1;
		check("normal analog", analog_ctrl_q, exp);
		check("normal data", pin_out_q, 7'h55);
		check("normal oe_n", pin_oe_n_q, 7'h4C);
		check("normal pullup", pin_pullup_q, 7'h0F);
		func_analog[130] <= 1'b1;
		n = 0;
		repeat (40) begin
			@(posedge core_clk);
			#1;
			if (dummy_busy_q === 1'b1) n++;
		end
		check("dummy length", n, 10);
	endtask
	task automatic t_limit(input bsa_code_type v, input logic lo,
		input logic hi, input logic ps);
		int n;
		n = 0;
		while (busy_q !== 1'b0 && n < 100) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		check("idle before start", busy_q, 1'b0);
		@(posedge core_clk);
		vin <= v;
		start <= 1'b1;
		@(posedge core_clk);
		start <= 1'b0;
		@(posedge core_clk);
		#1;
		check("busy", busy_q, 1'b1);
		n = 0;
		while (done_q !== 1'b1 && n < 20000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		check("done in time", n < 20000, 1'b1);
		check("low ok", low_ok_q, lo);
		check("high ok", high_ok_q, hi);
		check("pass", pass_q, ps);
		check("extest", extest_active_q, 1'b1);
		check("enable", analog_ctrl_q[130], 1'b1);
		check("code", analog_ctrl_q[128:119], `BSA_DAC_MID);
		check("mux", analog_ctrl_q[112:105], 8'h08);
		check("hold precharge_n_cell", {analog_ctrl_q[114], analog_ctrl_q[100]}, 2'h3);
		check("reserved", {analog_ctrl_q[135], analog_ctrl_q[132]}, 2'h0);
		check("pin data", pin_out_q, 7'h00);
		check("pin oe_n", pin_oe_n_q, 7'h7F);
		check("pin pullup", pin_pullup_q, 7'h00);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		repeat (60000) @(posedge core_clk);
		fails++;
		wrap_up();
	end
	initial begin
		sys_rst = 1'b1;
		start = 1'b0;
		lower_limit = 10'h123;
		upper_limit = 10'h143;
		mux_sel = `BSA_MUX_TEST;
		vin = 10'h000;
		comparator_out = 1'b0;
		pin_in = 7'h2A;
		func_analog = 44'h0;
		func_pin_data = 7'h00;
		func_pin_dir = 7'h00;
		func_pin_pullup = 7'h00;
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		t_normal();
		t_limit(10'h123, 1'b1, 1'b1, 1'b1);
		t_limit(10'h143, 1'b1, 1'b0, 1'b0);
		t_limit(10'h100, 1'b0, 1'b1, 1'b0);
		wrap_up();
	end
endmodule
